// File: verilog/clp_consts.svh
// Constants for the colour look-up palette port.
// Assumes inclusion by bare name from the package, the design, the checker and the bench.
`ifndef CLP_CONSTS_SVH
`define CLP_CONSTS_SVH

`define CLP_PORT_MASK 16'h03c6
`define CLP_PORT_RD_IDX 16'h03c7
`define CLP_PORT_WR_IDX 16'h03c8
`define CLP_PORT_DATA 16'h03c9
`define CLP_MASK_RESET 8'hff
`define CLP_STATE_RD 8'h00
`define CLP_STATE_WR 8'h03
`define CLP_ENTRIES 256
`define CLP_COLOR_W 6
`define CLP_FIFO_DEPTH 8
`define CLP_PIX_DIV 8
`define CLP_LAST_BYTE 2'h2

`endif

// File: verilog/clp_pkg.sv
// Types for the colour look-up palette port.
// Assumes clp_consts.svh is on the include path.
`default_nettype none
`include "clp_consts.svh"

package clp_pkg;
    typedef struct packed {
        logic [`CLP_COLOR_W-1:0] red;
        logic [`CLP_COLOR_W-1:0] green;
        logic [`CLP_COLOR_W-1:0] blue;
    } clp_entry_t;

    typedef struct packed {
        logic [7:0] index;
        clp_entry_t entry;
    } clp_commit_t;

    typedef struct packed {
        logic [7:0] index;
        logic blank;
    } clp_pixel_t;
endpackage : clp_pkg

`default_nettype wire

// File: verilog/clp_palette_port.sv
// Colour look-up palette with its processor byte port, plus its write FIFO.
// Assumes one clock mclk; processor strobes arrive asynchronously on pins,
// pixel inputs come from display logic on mclk and are taken on pix_en.
`default_nettype none
`include "clp_consts.svh"

////////////////////////////////////////////////////////////////////////////////
module clp_fifo #(
    parameter int WIDTH = 26,
    parameter int DEPTH = `CLP_FIFO_DEPTH
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0] cnt_q;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rp_q];

    always_ff @(posedge mclk) begin
        if (push) begin
            mem_q[wp_q] <= in_data;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : clp_fifo

////////////////////////////////////////////////////////////////////////////////
module clp_palette_port #(
    parameter int PIX_DIV = `CLP_PIX_DIV
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire clp_pkg::clp_pixel_t pixel_index_inputs,
    output logic pix_en,
    output clp_pkg::clp_entry_t colour_out,
    input wire logic [15:0] io_addr,
    input wire logic io_rd_n,
    input wire logic io_wr_n,
    input wire logic [7:0] io_data_in,
    output logic [7:0] io_data_out,
    output logic io_data_oe
);
    import clp_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Pixel rate enable
    logic [$clog2(PIX_DIV+1)-1:0] div_q;
    wire div_wrap = (div_q == $bits(div_q)'(PIX_DIV-1));

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            div_q <= '0;
        end else begin
            div_q <= div_wrap ? '0 : div_q + 1'b1;
        end
    end
    assign pix_en = div_wrap;

    ////////////////////////////////////////////////////////////////////////////
    // Strobe synchronisers; a level counts once stages two and three agree
    logic [2:0] rd_s_q;
    logic [2:0] wr_s_q;
    logic rd_lvl_q;
    logic wr_lvl_q;
    logic [15:0] addr_q;
    logic [7:0] wdata_q;
    logic [15:0] addr_s0_q;
    logic [15:0] addr_s1_q;
    logic [15:0] addr_s2_q;
    logic [7:0] data_s0_q;
    logic [7:0] data_s1_q;
    logic [7:0] data_s2_q;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rd_s_q <= 3'h0;
            wr_s_q <= 3'h0;
            rd_lvl_q <= 1'b0;
            wr_lvl_q <= 1'b0;
        end else begin
            rd_s_q <= {rd_s_q[1:0], ~io_rd_n};
            wr_s_q <= {wr_s_q[1:0], ~io_wr_n};
            if (rd_s_q[1] == rd_s_q[2]) begin
                rd_lvl_q <= rd_s_q[2];
            end
            if (wr_s_q[1] == wr_s_q[2]) begin
                wr_lvl_q <= wr_s_q[2];
            end
        end
    end

    wire rd_act = (rd_s_q[1] == rd_s_q[2]) && rd_s_q[2];
    wire wr_act = (wr_s_q[1] == wr_s_q[2]) && wr_s_q[2];
    wire rd_start = rd_act && !rd_lvl_q;
    wire rd_end = (rd_s_q[1] == rd_s_q[2]) && !rd_s_q[2] && rd_lvl_q;
    wire wr_end = (wr_s_q[1] == wr_s_q[2]) && !wr_s_q[2] && wr_lvl_q;

    // Address and data ride three stages beside the strobes, so a taken value
    // was sampled at the same edges that saw the strobe low; the host may move
    // the address as soon as its strobe rises, long before the sync sees it
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            addr_s0_q <= 16'h0000;
            addr_s1_q <= 16'h0000;
            addr_s2_q <= 16'h0000;
            data_s0_q <= 8'h00;
            data_s1_q <= 8'h00;
            data_s2_q <= 8'h00;
        end else begin
            addr_s0_q <= io_addr;
            addr_s1_q <= addr_s0_q;
            addr_s2_q <= addr_s1_q;
            data_s0_q <= io_data_in;
            data_s1_q <= data_s0_q;
            data_s2_q <= data_s1_q;
        end
    end

    wire addr_take = (rd_act || wr_act) && (addr_s1_q == addr_s2_q);
    wire data_take = wr_act && (data_s1_q == data_s2_q);

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            addr_q <= 16'h0000;
            wdata_q <= 8'h00;
        end else begin
            if (addr_take) begin
                addr_q <= addr_s2_q;
            end
            if (data_take) begin
                wdata_q <= data_s2_q;
            end
        end
    end

    // Decode the address being taken, so the first read byte is already right
    wire [15:0] addr_cur = addr_take ? addr_s2_q : addr_q;
    wire hit_mask = (addr_cur == `CLP_PORT_MASK);
    wire hit_ridx = (addr_cur == `CLP_PORT_RD_IDX);
    wire hit_widx = (addr_cur == `CLP_PORT_WR_IDX);
    wire hit_data = (addr_cur == `CLP_PORT_DATA);

    ////////////////////////////////////////////////////////////////////////////
    // Processor side state
    clp_entry_t pal_q [`CLP_ENTRIES];
    logic [7:0] mask_q;
    logic [7:0] index_q;
    logic wr_mode_q;
    logic [1:0] byte_q;
    clp_entry_t hold_q;
    logic fetch_q;
    logic commit_q;
    clp_commit_t commit_word_q;
    logic [7:0] rdata_q;
    logic oe_q;

    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [$bits(clp_commit_t)-1:0] fifo_out_raw;
    clp_commit_t fifo_out;
    assign fifo_out = clp_commit_t'(fifo_out_raw);

    wire idx_wr = wr_end && (hit_ridx || hit_widx);
    wire data_wr = wr_end && hit_data && wr_mode_q && !idx_wr;
    wire data_rd_done = rd_end && hit_data && !wr_mode_q;
    wire last_byte = (byte_q == `CLP_LAST_BYTE);
    wire do_fetch = fetch_q && !fifo_out_valid && !commit_q;
    wire push = commit_q && fifo_in_ready;
    wire [5:0] wbyte = wdata_q[5:0];

    logic [5:0] rd_colour;
    assign rd_colour = (byte_q == 2'h0) ? hold_q.red :
                       (byte_q == 2'h1) ? hold_q.green : hold_q.blue;

    logic [7:0] rd_value;
    assign rd_value = hit_mask ? mask_q :
                      hit_ridx ? (wr_mode_q ? `CLP_STATE_WR : `CLP_STATE_RD) :
                      hit_widx ? index_q :
                      hit_data ? {2'h0, rd_colour} : 8'h00;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            mask_q <= `CLP_MASK_RESET;
            index_q <= 8'h00;
            wr_mode_q <= 1'b1;
            byte_q <= 2'h0;
            hold_q <= '0;
            fetch_q <= 1'b0;
            commit_q <= 1'b0;
            commit_word_q <= '0;
            rdata_q <= 8'h00;
            oe_q <= 1'b0;
        end else begin
            // Reads drive data and read-mode data reads also step byte_q; index and state reads change nothing
            if (rd_start) begin
                oe_q <= 1'b1;
            end else if (!rd_act) begin
                oe_q <= 1'b0;
            end
            if (rd_act) begin
                rdata_q <= rd_value;
            end
            if (wr_end && hit_mask) begin
                mask_q <= wdata_q;
            end
            if (idx_wr) begin
                index_q <= wdata_q;
                wr_mode_q <= hit_widx;
                byte_q <= 2'h0;
                fetch_q <= hit_ridx;
            end else if (data_wr) begin
                case (byte_q)
                    2'h0: hold_q.red <= wbyte;
                    2'h1: hold_q.green <= wbyte;
                    default: hold_q.blue <= wbyte;
                endcase
                byte_q <= last_byte ? 2'h0 : byte_q + 2'h1;
                if (last_byte) begin
                    commit_word_q <= '{index: index_q,
                                       entry: '{red: hold_q.red, green: hold_q.green,
                                                blue: wbyte}};
                    commit_q <= 1'b1;
                    index_q <= index_q + 8'h01;
                end
            end else if (data_rd_done) begin
                byte_q <= last_byte ? 2'h0 : byte_q + 2'h1;
                fetch_q <= last_byte;
            end else if (do_fetch) begin
                hold_q <= pal_q[index_q];
                index_q <= index_q + 8'h01;
                fetch_q <= 1'b0;
            end
            if (push) begin
                commit_q <= 1'b0;
            end
        end
    end

    assign io_data_out = rdata_q;
    assign io_data_oe = oe_q;

    ////////////////////////////////////////////////////////////////////////////
    // Commit FIFO; drained only off pixel edges so the lookup never sees a torn write
    wire drain = fifo_out_valid && !pix_en;

    clp_fifo #(
        .WIDTH($bits(clp_commit_t)),
        .DEPTH(`CLP_FIFO_DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .in_valid(commit_q),
        .in_ready(fifo_in_ready),
        .in_data(commit_word_q),
        .out_valid(fifo_out_valid),
        .out_ready(drain),
        .out_data(fifo_out_raw)
    );

    genvar gi;
    generate
        for (gi = 0; gi < `CLP_ENTRIES; gi++) begin : g_entry
            always_ff @(posedge mclk) begin
                if (sys_rst) begin
                    pal_q[gi] <= '0;
                end else if (drain && fifo_out.index == 8'(gi)) begin
                    pal_q[gi] <= fifo_out.entry;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Pixel pipeline: sample, look up, blank, output on successive pixel edges
    clp_pixel_t pix0_q;
    clp_entry_t look_q;
    logic blank1_q;
    clp_entry_t stage2_q;
    clp_entry_t out_q;
    wire [7:0] sel_index = pix0_q.index & mask_q;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pix0_q <= '0;
            look_q <= '0;
            blank1_q <= 1'b1;
            stage2_q <= '0;
            out_q <= '0;
        end else if (pix_en) begin
            pix0_q <= pixel_index_inputs;
            look_q <= pal_q[sel_index];
            blank1_q <= pix0_q.blank;
            stage2_q <= blank1_q ? '0 : look_q;
            out_q <= stage2_q;
        end
    end

    assign colour_out = out_q;
endmodule : clp_palette_port

`default_nettype wire

// File: sim/clp_palette_port_properties.sv
// Pin-level checks of the palette port.
// Assumes a bind to clp_palette_port; sees only its ports.
`default_nettype none
`include "clp_consts.svh"
module clp_palette_port_properties #(
    parameter int PIX_DIV = 8
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire clp_pkg::clp_pixel_t pixel_index_inputs,
    input wire logic pix_en,
    input wire clp_pkg::clp_entry_t colour_out,
    input wire logic [15:0] io_addr,
    input wire logic io_rd_n,
    input wire logic io_wr_n,
    input wire logic [7:0] io_data_in,
    input wire logic [7:0] io_data_out,
    input wire logic io_data_oe
);
    import clp_pkg::*;
    logic [3:0] blk_q;
    logic [7:0] gap_q;
    logic seen_q;
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////////////////
    // Blank history at pixel edges and distance between pixel pulses
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            blk_q <= 4'h0;
            gap_q <= 8'h00;
            seen_q <= 1'b0;
        end else begin
            blk_q <= pix_en ? {blk_q[2:0], pixel_index_inputs.blank} : blk_q;
            gap_q <= pix_en ? 8'h01 : gap_q + 8'h01;
            seen_q <= seen_q | pix_en;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    chk_blank_zero: assert property (blk_q[3] |-> colour_out == '0)
        else $error("colour not zero while blanked");
    chk_colour_hold: assert property (!pix_en |=> $stable(colour_out))
        else $error("colour changed off a pixel edge");
    chk_pix_period: assert property (pix_en && seen_q |-> gap_q == PIX_DIV)
        else $error("pixel pulse period wrong");
    chk_pix_gap: assert property (seen_q && !pix_en |-> gap_q < PIX_DIV)
        else $error("pixel pulse missing");
    chk_oe_read: assert property (!io_rd_n [*6] |-> io_data_oe)
        else $error("data not driven during read");
    chk_oe_idle: assert property (io_rd_n [*6] |-> !io_data_oe)
        else $error("data driven without read");
    chk_state_bits: assert property ((io_addr == `CLP_PORT_RD_IDX && !io_rd_n) [*6]
        |-> io_data_out == `CLP_STATE_RD || io_data_out == `CLP_STATE_WR)
        else $error("mode state value wrong");
    chk_data_high: assert property ((io_addr == `CLP_PORT_DATA && !io_rd_n) [*6]
        |-> io_data_out[7:6] == 2'h0)
        else $error("colour byte upper bits set");
    chk_data_hold: assert property (io_rd_n [*6] |=> $stable(io_data_out))
        else $error("read data changed without read");
endmodule : clp_palette_port_properties
`default_nettype wire

// File: sim/clp_cpu_model.sv
// Processor model on the palette byte port.
// Assumes one clock mclk; the bench calls its access task.
`default_nettype none
module clp_cpu_model (
    input wire logic mclk,
    output var logic [15:0] io_addr,
    output var logic io_rd_n,
    output var logic io_wr_n,
    output var logic [7:0] io_data_in,
    input wire logic [7:0] io_data_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        io_addr = 16'h0000;
        io_rd_n = 1'b1;
        io_wr_n = 1'b1;
        io_data_in = 8'h00;
    end
    // One strobe held 6 cycles; lines inverted once released
    task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d,
            output logic [7:0] q);
        @(posedge mclk);
        io_addr <= a;
        io_data_in <= d;
        io_wr_n <= !w;
        io_rd_n <= w;
        repeat (6) @(posedge mclk);
        q = io_data_out;
        io_wr_n <= 1'b1;
        io_rd_n <= 1'b1;
        @(posedge mclk);
        io_addr <= ~a;
        io_data_in <= ~d;
        repeat (50) @(posedge mclk);
    endtask : acc
endmodule : clp_cpu_model
`default_nettype wire

// File: sim/clp_palette_port_tb.sv
// Self-checking bench of the palette port.
// Assumes package, design, model and checker compiled first.
`default_nettype none
`include "clp_consts.svh"
module clp_palette_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import clp_pkg::*;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    clp_pixel_t pxi = '{index: 8'h00, blank: 1'b1};
    clp_entry_t colour_out;
    logic pix_en, io_rd_n, io_wr_n, io_data_oe;
    logic [15:0] io_addr;
    logic [7:0] io_data_in, io_data_out, q;
    int error_cnt = 0;
    int n_checks = 0;
    always #2.5 mclk = ~mclk;
    clp_palette_port #(.PIX_DIV(4)) dut (.mclk(mclk), .sys_rst(sys_rst),
        .pixel_index_inputs(pxi), .pix_en(pix_en), .colour_out(colour_out),
        .io_addr(io_addr), .io_rd_n(io_rd_n), .io_wr_n(io_wr_n), .io_data_in(io_data_in),
        .io_data_out(io_data_out), .io_data_oe(io_data_oe));
    clp_cpu_model cpu (.mclk(mclk), .io_addr(io_addr), .io_rd_n(io_rd_n),
        .io_wr_n(io_wr_n), .io_data_in(io_data_in), .io_data_out(io_data_out));
    ////////////////////////////////////////////////////////////////////////////
    task automatic ck(input string n, input logic [23:0] e, input logic [23:0] s);
        n_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("unexpected %s exp %h got %h", n, e, s);
        end
    endtask : ck
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        cpu.acc(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        cpu.acc(1'b0, a, 8'h00, q);
        ck("io_data_out", {16'h0, e}, {16'h0, q});
    endtask : rd
    task automatic wgrp(input logic [23:0] b);
        for (int i = 2; i >= 0; i--) wr(`CLP_PORT_DATA, b[i*8 +: 8]);
    endtask : wgrp
    task automatic rgrp(input clp_entry_t e);
        rd(`CLP_PORT_DATA, {2'h0, e.red});
        rd(`CLP_PORT_DATA, {2'h0, e.green});
        rd(`CLP_PORT_DATA, {2'h0, e.blue});
    endtask : rgrp
    // Old colour two pixel edges after sampling, new colour after the third
    task automatic pix(input clp_pixel_t p, input clp_entry_t e0, input clp_entry_t e1);
        @(posedge mclk);
        pxi <= p;
        for (int k = 0; k < 4; k++) begin
            @(posedge mclk);
            while (pix_en !== 1'b1) @(posedge mclk);
            #1;
            if (k == 2) ck("colour_out", {6'h0, e0}, {6'h0, colour_out});
            if (k == 3) ck("colour_out", {6'h0, e1}, {6'h0, colour_out});
        end
    endtask : pix
    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : stop_test
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        stop_test();
    end
    initial begin
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        rd(`CLP_PORT_MASK, `CLP_MASK_RESET);
        rd(`CLP_PORT_RD_IDX, `CLP_STATE_WR);
        rd(`CLP_PORT_WR_IDX, 8'h00);
        rd(16'h03c5, 8'h00);
        wr(`CLP_PORT_WR_IDX, 8'h10);
        wgrp(24'hff2ac5);
        wgrp(24'h010203);
        rd(`CLP_PORT_WR_IDX, 8'h12);
        wr(`CLP_PORT_WR_IDX, 8'h20);
        wr(`CLP_PORT_DATA, 8'h11);
        rd(`CLP_PORT_RD_IDX, `CLP_STATE_WR);
        wr(`CLP_PORT_WR_IDX, 8'h20);
        wgrp(24'h070809);
        wr(`CLP_PORT_WR_IDX, 8'hff);
        wgrp(24'h3f3f3f);
        rd(`CLP_PORT_WR_IDX, 8'h00);
        wr(`CLP_PORT_RD_IDX, 8'h10);
        rd(`CLP_PORT_RD_IDX, `CLP_STATE_RD);
        rd(`CLP_PORT_WR_IDX, 8'h11);
        rgrp({6'h3f, 6'h2a, 6'h05});
        rgrp({6'h01, 6'h02, 6'h03});
        wr(`CLP_PORT_RD_IDX, 8'h10);
        rd(`CLP_PORT_DATA, 8'h3f);
        wr(`CLP_PORT_RD_IDX, 8'h20);
        rgrp({6'h07, 6'h08, 6'h09});
        wr(`CLP_PORT_RD_IDX, 8'hff);
        rgrp({6'h3f, 6'h3f, 6'h3f});
        wr(`CLP_PORT_MASK, 8'h1f);
        rd(`CLP_PORT_MASK, 8'h1f);
        pix('{index: 8'h30, blank: 1'b0}, '0, {6'h3f, 6'h2a, 6'h05});
        pix('{index: 8'h31, blank: 1'b0}, {6'h3f, 6'h2a, 6'h05}, {6'h01, 6'h02, 6'h03});
        pix('{index: 8'h31, blank: 1'b1}, {6'h01, 6'h02, 6'h03}, '0);
        stop_test();
    end
endmodule : clp_palette_port_tb
bind clp_palette_port clp_palette_port_properties #(.PIX_DIV(PIX_DIV)) chk (
    .mclk(mclk), .sys_rst(sys_rst), .pixel_index_inputs(pixel_index_inputs),
    .pix_en(pix_en), .colour_out(colour_out), .io_addr(io_addr), .io_rd_n(io_rd_n),
    .io_wr_n(io_wr_n), .io_data_in(io_data_in), .io_data_out(io_data_out),
    .io_data_oe(io_data_oe));
`default_nettype wire
